// [src/bnvra_defines.vh]
// Timing constants for the bytewide nonvolatile RAM controller.
// Assumes a 100 MHz ref_clk; counts derived from ns figures.
`ifndef BNVRA_DEFINES_VH
`define BNVRA_DEFINES_VH
`define BNVRA_CLK_PERIOD_NS 10
// Least times and the longest access time, rounded up to whole cycles
`define BNVRA_T_CA_MIN_NS   70
`define BNVRA_T_PC_MIN_NS   60
`define BNVRA_T_CE_MAX_NS   70
`define BNVRA_T_WP_MIN_NS   40
`define BNVRA_T_AH_MIN_NS   10
`define BNVRA_T_DH_MIN_NS   5
`define BNVRA_T_PU_MIN_NS   1000
`define BNVRA_CYC(ns) (((ns) + `BNVRA_CLK_PERIOD_NS - 1) / `BNVRA_CLK_PERIOD_NS)
`define BNVRA_CA_CYC  `BNVRA_CYC(`BNVRA_T_CA_MIN_NS)
`define BNVRA_PC_CYC  `BNVRA_CYC(`BNVRA_T_PC_MIN_NS)
`define BNVRA_CE_CYC  `BNVRA_CYC(`BNVRA_T_CE_MAX_NS)
`define BNVRA_PU_CYC  `BNVRA_CYC(`BNVRA_T_PU_MIN_NS)
`define BNVRA_ADDR_W  15
`define BNVRA_DATA_W  8
`endif

// [src/bnvra_timer.v]
// Down counter used for strobe phase timing.
// Assumes load and count values fit the parameter width.
`timescale 1ns/1ps
`default_nettype none
module bnvra_timer #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         ref_clk,
    input  wire         rst,
    // Control
    input  wire         load,
    input  wire [W-1:0] loadValue,
    // Status
    output wire         done
);
    reg [W-1:0] count;

    // Reload wins over counting
    always @(posedge ref_clk) begin
        if (rst) begin
            count <= {W{1'b0}};
        end else if (load) begin
            count <= loadValue;
        end else if (count != {W{1'b0}}) begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (count == {W{1'b0}});
endmodule
`default_nettype wire

// [src/bnvra_host.v]
// Controller driving the bytewide nonvolatile RAM pins.
// Assumes a user request port synchronous to ref_clk; pins registered.
// How it works
// RULE1: Device latches address on select fall.
// RULE2: Device keeps latched address during cycle.
// RULE3: Select is toggled, never held low.
// RULE4: Each access gets its own select fall.
// RULE5: Select high phase is the precharge.
// RULE6: Device never blocks accesses by supply.
// RULE7: No accesses while supply out of tolerance.
// RULE8: Select held high below minimum supply; a supply drop during S_ACCESS or S_HOLD leaves select low until S_HOLD ends.
// RULE9: Write low at select fall: write cycle.
// RULE10: Late write fall: read then write.
// RULE11: Output enable gates data drivers only.
// RULE12: Select high for precharge before fall.
// RULE13: Device finishes cycle; waits for precharge.
`timescale 1ns/1ps
`default_nettype none
`include "bnvra_defines.vh"
module bnvra_host #(
    parameter ADDR_W = `BNVRA_ADDR_W,
    parameter DATA_W = `BNVRA_DATA_W,
    parameter PU_CYC = `BNVRA_PU_CYC
) (
    // Clock and reset
    input  wire              ref_clk,
    input  wire              rst,
    // Supply monitor
    input  wire              supplyGood,
    // User request
    input  wire              reqValid,
    input  wire              reqWrite,
    input  wire [ADDR_W-1:0] reqAddr,
    input  wire [DATA_W-1:0] reqWData,
    output reg               reqReady,
    output reg               rspValid,
    output reg  [DATA_W-1:0] rspRData,
    // Memory pins
    output reg               chipSelN,
    output reg               writeEnN,
    output reg               outEnN,
    output reg  [ADDR_W-1:0] word_address_bus,
    input  wire [DATA_W-1:0] byte_data_bus_in,
    output reg  [DATA_W-1:0] byte_data_bus_out,
    output reg               byte_data_bus_oe_n
);
    localparam TW = 8;
    // Integer counts cut to timer width on purpose
    localparam integer  CA_CYC_I = `BNVRA_CA_CYC;
    localparam integer  PC_CYC_I = `BNVRA_PC_CYC;
    localparam integer  CE_CYC_I = `BNVRA_CE_CYC;
    localparam [TW-1:0] CA_CYC   = CA_CYC_I[TW-1:0];
    localparam [TW-1:0] PC_CYC   = PC_CYC_I[TW-1:0];
    localparam [TW-1:0] CE_CYC   = CE_CYC_I[TW-1:0];
    // Select stays low for the longer of active and access time
    localparam [TW-1:0] ACC_CYC  = (CE_CYC > CA_CYC) ? CE_CYC : CA_CYC;
    localparam [TW-1:0] HOLD_CYC = 8'h01;

    localparam [2:0] S_POWER  = 3'h0;
    localparam [2:0] S_IDLE   = 3'h1;
    localparam [2:0] S_ACCESS = 3'h2;
    localparam [2:0] S_HOLD   = 3'h3;
    localparam [2:0] S_PRECH  = 3'h4;

    reg  [2:0]    state;
    reg  [2:0]    next_state;
    reg           isWrite;
    reg           timerLoad;
    reg  [TW-1:0] timerValue;
    reg  [31:0]   puCount;
    wire          timerDone;
    wire          powerSettled;
    wire          reqTake;

    bnvra_timer #(.W(TW)) phaseTimer (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .load      (timerLoad),
        .loadValue (timerValue),
        .done      (timerDone)
    );

    // Supply must have stood good for the whole power-up wait
    assign powerSettled = supplyGood && (puCount >= PU_CYC);
    // A request is only taken in idle with good supply
    assign reqTake = (state == S_IDLE) && supplyGood && reqValid; // RULE7

    // Power-up wait restarts whenever the supply drops
    always @(posedge ref_clk) begin
        if (rst || !supplyGood) begin
            puCount <= 32'h00000000;
        end else if (puCount < PU_CYC) begin
            puCount <= puCount + 32'h00000001;
        end
    end

    // Next state and timer loads
    always @* begin
        next_state = state;
        timerLoad  = 1'b0;
        timerValue = {TW{1'b0}};
        case (state)
            S_POWER: begin
                if (powerSettled) begin
                    next_state = S_IDLE;
                end
            end
            S_IDLE: begin
                // No access starts while supply is out of tolerance
                if (!supplyGood) begin
                    next_state = S_POWER; // RULE7
                end else if (reqTake) begin
                    next_state = S_ACCESS; // RULE4
                    timerLoad  = 1'b1;
                    timerValue = ACC_CYC;
                end
            end
            S_ACCESS: begin
                if (timerDone) begin
                    next_state = S_HOLD;
                    timerLoad  = 1'b1;
                    timerValue = HOLD_CYC;
                end
            end
            S_HOLD: begin
                if (timerDone) begin
                    next_state = S_PRECH; // RULE3
                    timerLoad  = 1'b1;
                    timerValue = PC_CYC;
                end
            end
            S_PRECH: begin
                if (timerDone) begin
                    next_state = supplyGood ? S_IDLE : S_POWER; // RULE12
                end
            end
            default: begin
                next_state = S_POWER;
            end
        endcase
    end

    // Registered pin and user outputs
    always @(posedge ref_clk) begin
        if (rst) begin
            state              <= S_POWER;
            isWrite            <= 1'b0;
            chipSelN           <= 1'b1;
            writeEnN           <= 1'b1;
            outEnN             <= 1'b1;
            word_address_bus   <= {ADDR_W{1'b0}};
            byte_data_bus_out  <= {DATA_W{1'b0}};
            byte_data_bus_oe_n <= 1'b1;
            reqReady           <= 1'b0;
            rspValid           <= 1'b0;
            rspRData           <= {DATA_W{1'b0}};
        end else begin
            state    <= next_state;
            rspValid <= 1'b0;
            reqReady <= (next_state == S_IDLE) && supplyGood;
            case (state)
                S_IDLE: begin
                    if (next_state == S_ACCESS) begin
                        isWrite          <= reqWrite;
                        // Address settles with select fall; device latches it
                        word_address_bus <= reqAddr; // RULE1
                        chipSelN         <= 1'b0; // RULE4
                        // Write strobe low at select fall gives a select-led write
                        writeEnN         <= ~reqWrite; // RULE9
                        outEnN           <= reqWrite; // RULE11
                        byte_data_bus_out  <= reqWData;
                        byte_data_bus_oe_n <= ~reqWrite;
                    end else begin
                        // Strobes parked high between accesses
                        chipSelN           <= 1'b1; // RULE8
                        writeEnN           <= 1'b1;
                        outEnN             <= 1'b1;
                        byte_data_bus_oe_n <= 1'b1;
                    end
                end
                S_ACCESS: begin
                    if (timerDone) begin
                        // Write ends by strobe rise before select rise
                        writeEnN <= 1'b1; // RULE10
                        if (!isWrite) begin
                            rspRData <= byte_data_bus_in;
                            rspValid <= 1'b1;
                        end
                    end
                end
                S_HOLD: begin
                    if (timerDone) begin
                        chipSelN <= 1'b1; // RULE5
                        outEnN   <= 1'b1;
                        byte_data_bus_oe_n <= 1'b1;
                        if (isWrite) begin
                            rspValid <= 1'b1;
                        end
                    end
                end
                S_PRECH: begin
                    // Nothing but select high counts as precharge
                    chipSelN           <= 1'b1; // RULE12
                    writeEnN           <= 1'b1;
                    outEnN             <= 1'b1;
                    byte_data_bus_oe_n <= 1'b1;
                end
                // Power wait parks every strobe and the data driver, select included; the address bus keeps its value
                S_POWER: begin
                    chipSelN           <= 1'b1; // RULE8
                    writeEnN           <= 1'b1;
                    outEnN             <= 1'b1;
                    byte_data_bus_oe_n <= 1'b1;
                end
                default: begin
                    chipSelN <= 1'b1; // RULE8
                    writeEnN <= 1'b1;
                    outEnN   <= 1'b1;
                    byte_data_bus_oe_n <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [verification/bnvra_host_props.sv]
// Pin checker for the bytewide NV RAM controller.
// Assumes it is bound to bnvra_host and ref_clk runs at 100 MHz.
`timescale 1ns/1ps
`default_nettype none
module bnvra_host_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // User side
    input wire logic supplyGood,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqReady,
    input wire logic rspValid,
    // Memory strobes
    input wire logic chipSelN,
    input wire logic writeEnN,
    input wire logic outEnN
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Strobe shapes: select sampled low ten cycles, precharge six or more
    sel_fall_take_a: assert property ($fell(chipSelN) |-> $past(reqValid && reqReady))
        else $error("select fell without a request");
    sel_toggles_a: assert property ($fell(chipSelN) |-> !chipSelN[*5] ##1 !chipSelN[*5] ##1 chipSelN)
        else $error("select low time wrong");
    precharge_min_a: assert property ($rose(chipSelN) |-> chipSelN[*6])
        else $error("precharge too short");
    supply_ready_a: assert property (!supplyGood |=> !reqReady)
        else $error("ready while supply bad");
    supply_sel_a: assert property (!supplyGood && chipSelN |=> chipSelN)
        else $error("select fell while supply bad");
    write_shape_a: assert property (reqValid && reqReady && reqWrite |=>
        !writeEnN[*8] ##1 writeEnN ##1 !chipSelN ##1 chipSelN)
        else $error("write strobe shape wrong");
    read_start_a: assert property (reqValid && reqReady && !reqWrite |=>
        !chipSelN && !outEnN ##8 rspValid)
        else $error("read cycle timing wrong");
endmodule
bind bnvra_host bnvra_host_props i_props (.ref_clk, .rst, .supplyGood, .reqValid,
    .reqWrite, .reqReady, .rspValid, .chipSelN, .writeEnN, .outEnN);
`default_nettype wire

// [verification/bnvra_nvram_model.sv]
// Behavioural model of the bytewide NV RAM.
// Assumes strobes from the controller; latches on select and write edges, drives read data by level.
`timescale 1ns/1ps
`default_nettype none
module bnvra_nvram_model #(
    parameter ACC_NS = 70
) (
    // Strobes and address
    input wire logic        chipSelN,
    input wire logic        writeEnN,
    input wire logic        outEnN,
    input wire logic [14:0] addrBus,
    // Data bus
    input wire logic [7:0]  busIn,
    output logic     [7:0]  busOut,
    output logic            drive
);
    logic [7:0]  mem [0:32767];
    logic [14:0] lat;
    logic        isWrite = 0;
    logic        valid = 0;
    logic        open = 0;
    realtime     rose = -100;
    // Latch once per fall; a short precharge spoils the address
    always @(negedge chipSelN) begin
        lat = ($realtime - rose < 60) ? 'x : addrBus;
        isWrite = !writeEnN;
        open = 1;
        valid = 0;
        #ACC_NS valid = 1;
    end
    // Late strobe turns the read into a write
    always @(negedge writeEnN) if (!chipSelN) isWrite = 1;
    // First rising strobe ends the write; cycle finishes regardless
    always @(posedge writeEnN or posedge chipSelN) begin
        if (open && isWrite) mem[lat] = busIn;
        open = 0;
        if (chipSelN) begin
            rose = $realtime;
            valid = 0;
        end
    end
    // Drive only valid read data under output enable
    assign drive = !chipSelN && !outEnN && !isWrite && valid;
    assign busOut = mem[lat];
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the bytewide NV RAM controller.
// Assumes bnvra_host facing the behavioural memory model.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        ref_clk = 0, rst = 1, supplyGood = 1, reqValid = 0, reqWrite = 0;
    logic [14:0] reqAddr = 0, addrBus;
    logic [7:0]  reqWData = 0, rspRData, hostOut, devOut, busIn, lastBus = 0, q;
    logic        reqReady, rspValid, chipSelN, writeEnN, outEnN, hostOeN, devDrive;
    int          n_errors = 0, n_compared = 0, cyc = 0;
    // Released bus shows the inverse of its last value
    assign busIn = !hostOeN ? hostOut : devDrive ? devOut : ~lastBus;
    bnvra_host #(.PU_CYC(2)) i_dut (.ref_clk, .rst, .supplyGood, .reqValid, .reqWrite,
        .reqAddr, .reqWData, .reqReady, .rspValid, .rspRData, .chipSelN, .writeEnN,
        .outEnN, .word_address_bus(addrBus), .byte_data_bus_in(busIn),
        .byte_data_bus_out(hostOut), .byte_data_bus_oe_n(hostOeN));
    bnvra_nvram_model i_mem (.chipSelN, .writeEnN, .outEnN, .addrBus, .busIn,
        .busOut(devOut), .drive(devDrive));
    initial forever #5 ref_clk = ~ref_clk;
    // Hang guard
    always @(posedge ref_clk) begin
        lastBus <= busIn;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            complete_run;
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One request, held until taken, then wait for the answer
    task automatic access(input logic w, input logic [14:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {reqValid, reqWrite, reqAddr, reqWData} = {1'b1, w, a, d};
        while (reqReady !== 1'b1) @(negedge ref_clk);
        @(negedge ref_clk) reqValid = 0;
        while (rspValid !== 1'b1) @(negedge ref_clk);
        q = rspRData;
    endtask
    // Back-to-back writes at both ends of the space, then read back
    task automatic t_write_read;
        logic [14:0] a [4] = '{15'h0000, 15'h7FFF, 15'h2A55, 15'h0004};
        for (int i = 0; i < 4; i++) access(1'b1, a[i], {4'hA, i[3:0]});
        for (int i = 0; i < 4; i++) begin
            access(1'b0, a[i], 8'h00);
            check("read data", {4'hA, i[3:0]}, q);
        end
    endtask
    // Supply loss: request stays pending, select stays high
    task automatic t_supply;
        @(negedge ref_clk) supplyGood = 0;
        @(negedge ref_clk) reqValid = 1;
        repeat (10) begin
            @(negedge ref_clk);
            check("select", 8'h01, {7'h00, chipSelN});
            check("ready", 8'h00, {7'h00, reqReady});
        end
        reqValid = 0;
        supplyGood = 1;
        access(1'b0, 15'h7FFF, 8'h00);
        check("read after supply", 8'hA1, q);
    endtask
    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge ref_clk);
        rst = 0;
        t_write_read;
        t_supply;
        complete_run;
    end
endmodule
`default_nettype wire
